//--- design/tic_map.svh
// register offsets, field positions and reset values for the timer irq clear block
`ifndef TIC_MAP_SVH
`define TIC_MAP_SVH
// printed offsets are byte positions of 8-bit registers, not all multiples of four,
// so each is kept as an index and the bus address is four times the index
`define TIC_T0_CLR_LO_IDX 16'hF418
`define TIC_T0_CLR_HI_IDX 16'hF419
`define TIC_T1_CLR_LO_IDX 16'hF438
`define TIC_T1_CLR_HI_IDX 16'hF439
`define TIC_UPDATE_IDX 16'hF43A
`define TIC_T0_STATUS_IDX 16'hF416
`define TIC_T1_STATUS_IDX 16'hF436
`define TIC_IRQ_MASK_IDX 16'hF43B
`define TIC_ADDR_W 18
// field positions
`define TIC_FLAG_W 6
`define TIC_RERQ_BIT 7
`define TIC_NUM_CH 2
`define TIC_STATUS_RST 6'h00
`define TIC_MASK_RST 2'h0
`define TIC_RESP_OKAY 2'h0
`define TIC_RESP_SLVERR 2'h2
`endif

//--- design/tic_pkg.sv
// types shared by the timer irq clear block
package tic_pkg;
  typedef logic [5:0] tic_flags_t;
  typedef enum logic [1:0] {
    TIC_IDLE,
    TIC_WRESP,
    TIC_RRESP
  } tic_bus_state_t;
endpackage

//--- design/tic_chan_if.sv
// per-channel link between register slave and flag keeper
`timescale 1ns/10ps
interface tic_chan_if;
  logic [5:0] set_ev;
  logic [5:0] clr;
  logic rerq;
  logic [5:0] status;
  logic irq_pulse;
  modport keeper (input set_ev, input clr, input rerq, output status, output irq_pulse);
  modport ctrl (output set_ev, output clr, output rerq, input status, input irq_pulse);
endinterface

//--- design/tic_chan.sv
// one timer channel's interrupt status flags and request generator
`timescale 1ns/10ps
`include "tic_map.svh"
module tic_chan (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  tic_chan_if.keeper ch
);
  typedef struct packed {
    logic [5:0] status;
    logic irq;
  } tic_chan_state_t;
  tic_chan_state_t state_reg;
  tic_chan_state_t state_next;

  // flag update and request generation
  always_comb begin
    logic [5:0] fresh;
    fresh = ch.set_ev & ~state_reg.status;
    state_next = state_reg;
    // set beats clear so a same-cycle event survives
    state_next.status = (state_reg.status & ~ch.clr) | ch.set_ev;
    state_next.irq = 1'b0;
    // only a new event into an all-clear status raises a fresh request
    if (state_reg.status == `TIC_STATUS_RST && fresh != 6'h00) begin
      state_next.irq = 1'b1;
    end
    // re-request while sources remain unhandled after clearing
    if (ch.rerq && state_next.status != `TIC_STATUS_RST) begin
      state_next.irq = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ch.status = state_reg.status;
  assign ch.irq_pulse = state_reg.irq;
endmodule

//--- design/tic_top.sv
// timer interrupt clear and update register block with axi4-lite slave
//
// Summary of operation
// - writing one to clear bits 5..0 clears matching status flag; zero does nothing
// - reading a clear register always returns zero
// - bit5 emergency, 4 trigger start, 3 trigger stop, 2 event B, 1 A, 0 cyclic
// - writing one to bit 15 re-raises request if any flag still set
// - update register bit n belongs to channel n
// - update bits of missing channels ignore writes and read zero
// - writing one to update bit loads buffered period, events, dead time to active
// - no fresh request while any status flag of that channel stays set
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "tic_map.svh"
module tic_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // axi4-lite slave
  input wire logic [`TIC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TIC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt events from the timer core, one bit per flag
  input wire logic [5:0] ch0_event_i,
  input wire logic [5:0] ch1_event_i,
  // per-channel requests to the interrupt controller
  output logic [1:0] chan_irq_req_o,
  // one-cycle buffer-to-active load strobes
  output logic [1:0] chan_update_o,
  // level interrupt of unmasked status
  output logic irq_o
);
  typedef struct packed {
    tic_pkg::tic_bus_state_t wst;
    tic_pkg::tic_bus_state_t rst;
    logic aw_got;
    logic w_got;
    logic [`TIC_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mask;
    logic [1:0] update;
    logic [1:0] irq_req;
  } tic_top_state_t;
  tic_top_state_t state_reg;
  tic_top_state_t state_next;

  tic_chan_if ch0_if();
  tic_chan_if ch1_if();

  // word index from a byte address
  function automatic logic [15:0] tic_idx(input logic [`TIC_ADDR_W-1:0] a);
    tic_idx = a[`TIC_ADDR_W-1:2];
  endfunction

  // decode which index is mapped
  function automatic logic tic_mapped(input logic [15:0] i);
    tic_mapped = (i == `TIC_T0_CLR_LO_IDX) || (i == `TIC_T0_CLR_HI_IDX) ||
                 (i == `TIC_T1_CLR_LO_IDX) || (i == `TIC_T1_CLR_HI_IDX) ||
                 (i == `TIC_UPDATE_IDX) || (i == `TIC_T0_STATUS_IDX) ||
                 (i == `TIC_T1_STATUS_IDX) || (i == `TIC_IRQ_MASK_IDX);
  endfunction

  logic wr_fire;
  logic [15:0] wr_idx;
  logic [7:0] wr_byte;
  logic [1:0] sticky;

  assign wr_fire = state_reg.wst == tic_pkg::TIC_IDLE && state_reg.aw_got && state_reg.w_got;
  assign wr_idx = tic_idx(state_reg.awaddr);
  // 8-bit registers live in byte lane 0
  assign wr_byte = state_reg.wstrb[0] ? state_reg.wdata[7:0] : 8'h00;
  assign sticky = {ch1_if.status != 6'h00, ch0_if.status != 6'h00};

  // clear strobes and re-request toward the channel keepers
  always_comb begin
    ch0_if.set_ev = ch0_event_i;
    ch1_if.set_ev = ch1_event_i;
    ch0_if.clr = 6'h00;
    ch1_if.clr = 6'h00;
    ch0_if.rerq = 1'b0;
    ch1_if.rerq = 1'b0;
    if (wr_fire) begin
      // only ones act, zeros leave flags alone; bits 7..6 ignored
      if (wr_idx == `TIC_T0_CLR_LO_IDX) begin
        ch0_if.clr = wr_byte[5:0];
      end
      if (wr_idx == `TIC_T1_CLR_LO_IDX) begin
        ch1_if.clr = wr_byte[5:0];
      end
      // re-request is bit 15 of the word, bit 7 of the high byte
      if (wr_idx == `TIC_T0_CLR_HI_IDX) begin
        ch0_if.rerq = wr_byte[`TIC_RERQ_BIT];
      end
      if (wr_idx == `TIC_T1_CLR_HI_IDX) begin
        ch1_if.rerq = wr_byte[`TIC_RERQ_BIT];
      end
    end
  end

  tic_chan u_ch0 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ch(ch0_if.keeper)
  );

  tic_chan u_ch1 (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ch(ch1_if.keeper)
  );

  // bus sequencing, register writes and read data
  always_comb begin
    logic [15:0] ridx;
    ridx = tic_idx(s_axi_araddr);
    state_next = state_reg;
    state_next.update = 2'h0;
    state_next.irq_req = {ch1_if.irq_pulse, ch0_if.irq_pulse};
    // write address and data taken in either order
    if (s_axi_awvalid && !state_reg.aw_got && state_reg.wst == tic_pkg::TIC_IDLE) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_got && state_reg.wst == tic_pkg::TIC_IDLE) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.wst = tic_pkg::TIC_WRESP;
      state_next.bresp = tic_mapped(wr_idx) ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
      if (wr_idx == `TIC_UPDATE_IDX) begin
        // only implemented channel bits survive, upper bits dropped
        state_next.update = wr_byte[`TIC_NUM_CH-1:0];
      end
      if (wr_idx == `TIC_IRQ_MASK_IDX) begin
        state_next.mask = wr_byte[1:0];
      end
    end
    if (state_reg.wst == tic_pkg::TIC_WRESP && s_axi_bready) begin
      state_next.wst = tic_pkg::TIC_IDLE;
    end
    // read channel: one cycle to answer
    if (state_reg.rst == tic_pkg::TIC_IDLE && s_axi_arvalid) begin
      state_next.rst = tic_pkg::TIC_RRESP;
      state_next.rresp = tic_mapped(ridx) ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
      state_next.rdata = 32'h0000_0000;
      // clear and update registers are write only, read back zero
      if (ridx == `TIC_T0_STATUS_IDX) begin
        state_next.rdata = {26'h0, ch0_if.status};
      end else if (ridx == `TIC_T1_STATUS_IDX) begin
        state_next.rdata = {26'h0, ch1_if.status};
      end else if (ridx == `TIC_IRQ_MASK_IDX) begin
        state_next.rdata = {30'h0, state_reg.mask};
      end
    end
    if (state_reg.rst == tic_pkg::TIC_RRESP && s_axi_rready) begin
      state_next.rst = tic_pkg::TIC_IDLE;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = state_reg.wst == tic_pkg::TIC_IDLE && !state_reg.aw_got;
  assign s_axi_wready = state_reg.wst == tic_pkg::TIC_IDLE && !state_reg.w_got;
  assign s_axi_bvalid = state_reg.wst == tic_pkg::TIC_WRESP;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.rst == tic_pkg::TIC_IDLE;
  assign s_axi_rvalid = state_reg.rst == tic_pkg::TIC_RRESP;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign chan_irq_req_o = state_reg.irq_req;
  assign chan_update_o = state_reg.update;
  // level interrupt while any unmasked channel has a flag set
  assign irq_o = |(sticky & state_reg.mask);
endmodule

//--- test/tic_top_sva.sv
// port-level assertion checker for the timer irq clear block
`timescale 1ns/10ps
module tic_top_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] chan_irq_req_o,
  input wire logic [1:0] chan_update_o
);
  // everything here lives in the one system clock domain
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  write_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  clear_reads_zero_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[17:2] inside {16'hF418, 16'hF419, 16'hF438, 16'hF439}
    |=> s_axi_rdata == 32'h0) else $error("clear register read nonzero");
  update_cause_a: assert property (chan_update_o != 2'h0 |-> $rose(s_axi_bvalid))
    else $error("update strobe without write");
  req_single_a: assert property (chan_irq_req_o[1] |=> !chan_irq_req_o[1])
    else $error("request repeated");
  req_single_zero_a: assert property (chan_irq_req_o[0] |=> !chan_irq_req_o[0])
    else $error("channel zero request repeated");
endmodule

//--- test/tb.sv
// self-checking bench for the timer irq clear block
`timescale 1ns/10ps
`include "tic_map.svh"
module tb;
  logic clk_i, sys_rst_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, irq_o;
  logic [17:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, chan_irq_req_o, chan_update_o, br, rr;
  logic [5:0] ch0_event_i, ch1_event_i;
  int errors, n_tests, nreq[2], nupd[2];
  tic_top u_tic_top (.*);
  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // tally one-cycle pulses mid-cycle, where they are settled
  always @(negedge clk_i) for (int c = 0; c < 2; c++) begin
    nreq[c] += int'(chan_irq_req_o[c] === 1'b1);
    nupd[c] += int'(chan_update_o[c] === 1'b1);
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // wait for a handshake signal, capturing what the answer carries
  task automatic hs(ref logic s);
    logic a;
    do begin
      @(negedge clk_i);
      a = s;
      rdv = s_axi_rdata;
      rr = s_axi_rresp;
      br = s_axi_bresp;
      @(posedge clk_i);
    end while (a !== 1'b1);
  endtask
  // address and data may be taken in either order, so track each
  task wr(input logic [15:0] i, input logic [7:0] d);
    logic a, w, ta, tw;
    ta = 0;
    tw = 0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk_i);
      a = s_axi_awready & !ta;
      w = s_axi_wready & !tw;
      @(posedge clk_i);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      ta |= a;
      tw |= w;
    end
    hs(s_axi_bvalid);
  endtask
  task rd(input logic [15:0] i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    hs(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    hs(s_axi_rvalid);
  endtask
  // one-cycle event pulse, then time for flag and request to land
  task ev(input int c, input logic [5:0] b);
    if (c == 0) ch0_event_i <= b;
    else ch1_event_i <= b;
    @(posedge clk_i);
    ch0_event_i <= 6'h00;
    ch1_event_i <= 6'h00;
    repeat (3) @(posedge clk_i);
  endtask
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict;
  end
  // per channel: flags, clears, re-request, mask, update
  initial begin
    logic [15:0] lo, hi, st;
    int b, b2;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, ch0_event_i, ch1_event_i} = '0;
    s_axi_wstrb = 4'hF;
    // response readies stay high so back-to-back calls never toggle them in one step
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      lo = c ? `TIC_T1_CLR_LO_IDX : `TIC_T0_CLR_LO_IDX;
      hi = c ? `TIC_T1_CLR_HI_IDX : `TIC_T0_CLR_HI_IDX;
      st = c ? `TIC_T1_STATUS_IDX : `TIC_T0_STATUS_IDX;
      b = nreq[c];
      ev(c, 6'h3F);
      chk(nreq[c] - b, 1);
      ev(c, 6'h01);
      chk(nreq[c] - b, 1);
      wr(lo, 8'h00);
      chk(br, 2'h0);
      rd(st);
      chk(rdv, 32'h3F);
      for (int k = 0; k < 6; k++) begin
        wr(lo, 8'h01 << k);
        rd(st);
        chk(rdv, 32'h3F & (32'h3F << (k + 1)));
        if (k == 2 || k == 5) begin
          b = nreq[c];
          wr(hi, 8'h80);
          repeat (3) @(posedge clk_i);
          chk(nreq[c] - b, k == 2);
        end
      end
      rd(lo);
      chk(rdv, 32'h0);
      rd(hi);
      chk(rdv, 32'h0);
      ev(c, 6'h04);
      wr(`TIC_IRQ_MASK_IDX, 8'h01 << c);
      chk(irq_o, 1'b1);
      wr(`TIC_IRQ_MASK_IDX, 8'h00);
      chk(irq_o, 1'b0);
      wr(lo, 8'h04);
      b = nupd[c];
      b2 = nupd[1 - c];
      wr(`TIC_UPDATE_IDX, 8'h01 << c);
      chk(nupd[c] - b, 1);
      chk(nupd[1 - c] - b2, 0);
    end
    b = nupd[0] + nupd[1];
    wr(`TIC_UPDATE_IDX, 8'hFC);
    chk(nupd[0] + nupd[1] - b, 0);
    rd(`TIC_UPDATE_IDX);
    chk(rdv, 32'h0);
    rd(16'h0000);
    chk(rr, 2'h2);
    wr(16'h0000, 8'h01);
    chk(br, 2'h2);
    give_verdict;
  end
endmodule
bind tic_top tic_top_chk u_tic_top_chk (.*);
